// [rtl/olc_defs.svh]
// Function
// [R1] Clearing layer enable bit zero requests disable
// [R2] Commit flag bit five applies pending updates
// [R3] Disable and commit same frame: no sync loss
// [R4] Split across boundary: sync loss one frame
// [R5] Sync-loss frame drives all pixels zero
// [R6] Normal output resumes after commit without software
// [R7] Software parks layer off-screen before disabling
// [R8] Software tracks parked layers per overlay
// [R9] Software waits ten cycles after first commit
// [R10] Software disables tracked layers, commits again
// [R11] Pending latched at frame boundary, commit auto-clears
`ifndef OLC_DEFS_SVH
`define OLC_DEFS_SVH
`define OLC_NUM_LAYERS      4
`define OLC_ADDR_VP_CTRL    8'h00
`define OLC_ADDR_LAYER0     8'h10
`define OLC_ADDR_PLACE0     8'h20
`define OLC_ADDR_IRQ_STAT   8'h30
`define OLC_ADDR_IRQ_CLR    8'h34
`define OLC_ADDR_IRQ_EN     8'h38
`define OLC_ADDR_STATUS     8'h3c
`define OLC_COMMIT_BIT      5
`define OLC_ENABLE_BIT      0
`define OLC_POSX_LSB        6
`define OLC_POSX_MSB        17
`define OLC_POSY_LSB        19
`define OLC_POSY_MSB        30
`define OLC_POS_MAX         12'hfff
`define OLC_H_ACTIVE        12'h010
`define OLC_V_ACTIVE        12'h008
`define OLC_H_TOTAL         12'h014
`define OLC_V_TOTAL         12'h00a
`define OLC_IRQ_FRAME       0
`define OLC_IRQ_SYNCLOST    1
`define OLC_IRQ_COMMIT      2
`define OLC_RESP_OKAY       2'b00
`define OLC_RESP_SLVERR     2'b10
`endif

// [rtl/olc_pkg.sv]
package olc_pkg;
  typedef struct packed {
    logic        valid;
    logic        hsync;
    logic        vsync;
    logic [23:0] data;
  } olc_pix_t;
  typedef struct packed {
    logic        enable;
    logic [11:0] posx;
    logic [11:0] posy;
  } olc_layer_t;
  typedef enum logic [2:0] {
    OLC_NORMAL   = 3'b001,
    OLC_ARMED    = 3'b010,
    OLC_SYNCLOST = 3'b100
  } olc_state_t;
endpackage

// [rtl/olc_timing.sv]
`timescale 1ns/100ps
`include "olc_defs.svh"
module olc_timing (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  output logic [11:0]      hcnt,
  output logic [11:0]      vcnt,
  output logic             frame_end
);
  logic [11:0] hcnt_ff;
  logic [11:0] vcnt_ff;

  // Raster counters; frame_end marks the last pixel slot of a frame.
  assign frame_end = (hcnt_ff == `OLC_H_TOTAL - 12'h001) && (vcnt_ff == `OLC_V_TOTAL - 12'h001);
  assign hcnt      = hcnt_ff;
  assign vcnt      = vcnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hcnt_ff <= 12'h000;
      vcnt_ff <= 12'h000;
    end else if (hcnt_ff == `OLC_H_TOTAL - 12'h001) begin
      hcnt_ff <= 12'h000;
      vcnt_ff <= frame_end ? 12'h000 : vcnt_ff + 12'h001;
    end else begin
      hcnt_ff <= hcnt_ff + 12'h001;
    end
  end
endmodule

// [rtl/olc_top.sv]
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "olc_defs.svh"
module olc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output olc_pkg::olc_pix_t pix_out,
  output logic             sync_lost,
  output logic             irq
);
  localparam int NL = `OLC_NUM_LAYERS;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  olc_pkg::olc_layer_t   pend_ff [NL];
  olc_pkg::olc_layer_t   act_ff  [NL];
  logic [NL-1:0]         dis_pend_ff;
  logic                  commit_ff;
  olc_pkg::olc_state_t   state_ff;
  logic [2:0]            irq_stat_ff;
  logic [2:0]            irq_en_ff;
  logic                  aw_got_ff;
  logic                  w_got_ff;
  logic [7:0]            awaddr_ff;
  logic [31:0]           wdata_ff;
  logic [3:0]            wstrb_ff;
  olc_pkg::olc_pix_t     pix_ff;
  logic [11:0]           hcnt;
  logic [11:0]           vcnt;
  logic                  frame_end;
  logic                  wr_fire;
  logic                  commit_wr;
  logic                  any_disable;
  logic                  boundary_commit;
  logic [31:0]           rd_val;
  logic                  rd_ok;

  olc_timing u_timing (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .hcnt      (hcnt),
    .vcnt      (vcnt),
    .frame_end (frame_end)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are taken independently; the write fires once both are held.
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
  assign wr_fire       = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // Write response; only addresses above the status register answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OLC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_ff <= `OLC_ADDR_STATUS) ? `OLC_RESP_OKAY : `OLC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign commit_wr = wr_fire && (awaddr_ff == `OLC_ADDR_VP_CTRL) && wstrb_ff[0] && wdata_ff[`OLC_COMMIT_BIT];
  assign boundary_commit = frame_end && commit_ff;

  // ----------------------------------------------------------------
  // Layer registers
  // ----------------------------------------------------------------
  // Each layer has a pending attribute and placement image and an active copy.
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_layer
      logic attr_wr;
      logic place_wr;
      assign attr_wr  = wr_fire && (awaddr_ff == `OLC_ADDR_LAYER0 + 8'(4 * g)) && wstrb_ff[0];
      assign place_wr = wr_fire && (awaddr_ff == `OLC_ADDR_PLACE0 + 8'(4 * g)) && (&wstrb_ff);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pend_ff[g]     <= '0;
          act_ff[g]      <= '0;
          dis_pend_ff[g] <= 1'b0;
        end else begin
          if (attr_wr) begin
            pend_ff[g].enable <= wdata_ff[`OLC_ENABLE_BIT];
          end
          if (place_wr) begin
            pend_ff[g].posx <= wdata_ff[`OLC_POSX_MSB:`OLC_POSX_LSB];
            pend_ff[g].posy <= wdata_ff[`OLC_POSY_MSB:`OLC_POSY_LSB];
          end
          // A one-to-zero enable write is a pending disable until committed.
          if (attr_wr && !wdata_ff[`OLC_ENABLE_BIT] && act_ff[g].enable) begin
            dis_pend_ff[g] <= 1'b1; // [R1]
          end else if (boundary_commit) begin
            dis_pend_ff[g] <= 1'b0;
          end
          // Active copy updates only at a committed frame boundary.
          if (boundary_commit) begin
            act_ff[g] <= pend_ff[g]; // [R11]
          end
        end
      end
    end
  endgenerate

  assign any_disable = |dis_pend_ff;

  // ----------------------------------------------------------------
  // Commit flag and sync-loss sequencer
  // ----------------------------------------------------------------
  // The flag auto-clears when its boundary is consumed; a new write wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      commit_ff <= 1'b0;
    end else if (commit_wr) begin
      commit_ff <= 1'b1; // [R2]
    end else if (frame_end) begin
      commit_ff <= 1'b0; // [R11]
    end
  end

  // ARMED: a disable is pending and its frame has ended without a commit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= olc_pkg::OLC_NORMAL;
    end else begin
      case (state_ff)
        olc_pkg::OLC_NORMAL: begin
          if (frame_end && any_disable && !commit_ff && !commit_wr) begin
            state_ff <= olc_pkg::OLC_ARMED; // [R3]
          end
        end
        olc_pkg::OLC_ARMED: begin
          if (frame_end && commit_ff) begin
            state_ff <= olc_pkg::OLC_SYNCLOST; // [R4]
          end else if (!any_disable) begin
            state_ff <= olc_pkg::OLC_NORMAL;
          end
        end
        olc_pkg::OLC_SYNCLOST: begin
          if (frame_end) begin
            state_ff <= olc_pkg::OLC_NORMAL; // [R6]
          end
        end
        default: state_ff <= olc_pkg::OLC_NORMAL;
      endcase
    end
  end

  assign sync_lost = (state_ff == olc_pkg::OLC_SYNCLOST);

  // ----------------------------------------------------------------
  // Pixel output
  // ----------------------------------------------------------------
  // Pixel shows the highest enabled layer covering the raster point; blank when lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_ff <= '0;
    end else begin
      pix_ff.valid <= (hcnt < `OLC_H_ACTIVE) && (vcnt < `OLC_V_ACTIVE);
      pix_ff.hsync <= (hcnt >= `OLC_H_ACTIVE);
      pix_ff.vsync <= (vcnt >= `OLC_V_ACTIVE);
      pix_ff.data  <= 24'h000000;
      if (!sync_lost) begin
        for (int i = 0; i < NL; i++) begin
          if (act_ff[i].enable && hcnt >= act_ff[i].posx && vcnt >= act_ff[i].posy) begin
            pix_ff.data <= {8'h00, 8'(i + 1), 8'hff};
          end
        end
      end else begin
        pix_ff.data <= 24'h000000; // [R5]
      end
    end
  end

  assign pix_out = pix_ff;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky events; a set in the clear cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= 3'h0;
      irq_en_ff   <= 3'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((wr_fire && awaddr_ff == `OLC_ADDR_IRQ_CLR) ? wdata_ff[2:0] : 3'h0))
                   | {boundary_commit, (frame_end && state_ff == olc_pkg::OLC_ARMED && commit_ff), frame_end};
      if (wr_fire && awaddr_ff == `OLC_ADDR_IRQ_EN) begin
        irq_en_ff <= wdata_ff[2:0];
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr == `OLC_ADDR_VP_CTRL) begin
      rd_val[`OLC_COMMIT_BIT] = commit_ff;
    end else if (s_axi_araddr == `OLC_ADDR_IRQ_STAT) begin
      rd_val[2:0] = irq_stat_ff;
    end else if (s_axi_araddr == `OLC_ADDR_IRQ_EN) begin
      rd_val[2:0] = irq_en_ff;
    end else if (s_axi_araddr == `OLC_ADDR_IRQ_CLR) begin
      rd_val = 32'h0000_0000;
    end else if (s_axi_araddr == `OLC_ADDR_STATUS) begin
      rd_val = {21'h0, dis_pend_ff, 4'h0, state_ff};
    end else begin
      rd_ok = 1'b0;
      for (int i = 0; i < NL; i++) begin
        if (s_axi_araddr == `OLC_ADDR_LAYER0 + 8'(4 * i)) begin
          rd_val = {31'h0, pend_ff[i].enable};
          rd_ok  = 1'b1;
        end
        if (s_axi_araddr == `OLC_ADDR_PLACE0 + 8'(4 * i)) begin
          rd_val = {1'b0, pend_ff[i].posy, 1'b0, pend_ff[i].posx, 6'h00};
          rd_ok  = 1'b1;
        end
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `OLC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? `OLC_RESP_OKAY : `OLC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_blank_when_lost: assert property (sync_lost |=> pix_out.data == 24'h000000) // [R5]
    else $error("Pixel data not zero in sync-loss frame.");
  chk_commit_autoclear: assert property (frame_end && !commit_wr |=> !commit_ff) // [R11]
    else $error("Commit flag survived frame boundary.");
  chk_commit_sets: assert property (commit_wr |=> commit_ff) // [R2]
    else $error("Commit write did not set flag.");
  chk_lost_one_frame: assert property (sync_lost && !frame_end |=> sync_lost) // [R4]
    else $error("Sync loss ended early.");
  chk_lost_ends: assert property (sync_lost && frame_end |=> !sync_lost) // [R6]
    else $error("Sync loss lasted beyond one frame.");
  chk_same_frame_ok: assert property (state_ff == olc_pkg::OLC_NORMAL && frame_end && commit_ff
      |=> state_ff == olc_pkg::OLC_NORMAL) // [R3]
    else $error("Sync loss raised for same-frame commit.");
  chk_active_latch: assert property (boundary_commit |=> act_ff[0] == $past(pend_ff[0])) // [R11]
    else $error("Active layer not latched at boundary.");
  chk_disable_pend: assert property (wr_fire && awaddr_ff == `OLC_ADDR_LAYER0 && wstrb_ff[0]
      && !wdata_ff[`OLC_ENABLE_BIT] && act_ff[0].enable && !boundary_commit |=> dis_pend_ff[0]) // [R1]
    else $error("Layer disable not recorded as pending.");
  chk_act_hold: assert property (!boundary_commit |=> $stable(act_ff[0])) // [R11]
    else $error("Active layer changed without commit.");

  cov_sync_lost: cover property ($rose(sync_lost));
  cov_clean_commit: cover property (boundary_commit && state_ff == olc_pkg::OLC_NORMAL && any_disable);
  cov_irq: cover property ($rose(irq));
endmodule

// [sim/olc_panel.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Panel model counting what the link shows
// ----------------------------------------
module olc_panel (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire olc_pkg::olc_pix_t pix,
  input  wire logic              sync_lost,
  input  wire logic              clr,
  input  wire logic [23:0]       match,
  output logic [15:0]            hits_ff,
  output logic [15:0]            lost_ff,
  output logic [15:0]            bad_ff,
  output logic [15:0]            hrise_ff,
  output logic [15:0]            vrise_ff
);
  logic lost_d_ff;
  logic hs_d_ff;
  logic vs_d_ff;

  // Counts matching slots, sync-loss cycles, non-blank slots of the lost frame and sync edges.
  // Slots leave one register after the raster state, so the lost flag is delayed to match them.
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      hits_ff   <= 16'h0000;
      lost_ff   <= 16'h0000;
      bad_ff    <= 16'h0000;
      hrise_ff  <= 16'h0000;
      vrise_ff  <= 16'h0000;
      lost_d_ff <= 1'b0;
      hs_d_ff   <= 1'b0;
      vs_d_ff   <= 1'b0;
    end else begin
      lost_d_ff <= sync_lost;
      hs_d_ff   <= pix.hsync;
      vs_d_ff   <= pix.vsync;
      if (pix.valid && pix.data === match) hits_ff <= hits_ff + 16'h0001;
      if (sync_lost) lost_ff <= lost_ff + 16'h0001;
      if (lost_d_ff && pix.data !== 24'h000000) bad_ff <= bad_ff + 16'h0001;
      if (pix.hsync === 1'b1 && !hs_d_ff) hrise_ff <= hrise_ff + 16'h0001;
      if (pix.vsync === 1'b1 && !vs_d_ff) vrise_ff <= vrise_ff + 16'h0001;
    end
  end
endmodule

// [sim/overlay_layer_disable_commit_bench.sv]
`timescale 1ns/100ps
`include "olc_defs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module overlay_layer_disable_commit_bench;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [7:0]        awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]       wdata = 32'h0, rdata, rd;
  logic [3:0]        wstrb = 4'hf;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, sync_lost, irq, clr = 1'b0;
  logic [1:0]        bresp, rresp, resp;
  logic [23:0]       match = 24'h0;
  logic [15:0]       hits, lost, bad, hrise, vrise;
  logic [3:0]        tracker = 4'h0;
  logic [1:0]        k;
  logic [11:0]       px, py;
  olc_pkg::olc_pix_t pix;
  int                seed = 32'h19871600;
  int                miscompares = 0;
  int                num_checks = 0;

  // --------------------------
  // Clock, design and panel
  // --------------------------
  // Clock of 25 ns period.
  always #12.5 aclk = ~aclk;

  olc_top olc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pix_out(pix),
    .sync_lost(sync_lost), .irq(irq));

  olc_panel olc_panel_i (.aclk(aclk), .aresetn(aresetn), .pix(pix), .sync_lost(sync_lost), .clr(clr),
    .match(match), .hits_ff(hits), .lost_ff(lost), .bad_ff(bad), .hrise_ff(hrise), .vrise_ff(vrise));

  // --------------------------
  // Bus tasks and expectations
  // --------------------------
  // Writes one word, holding each channel until it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 100);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 100) miscompares++;
  endtask

  // Reads one word into rd and resp.
  task automatic rdw(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 100);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 100) miscompares++;
  endtask

  // Clears the frame event and waits for the next frame boundary.
  task automatic wait_frame;
    int n;
    wr(`OLC_ADDR_IRQ_CLR, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 300) miscompares++;
  endtask

  // Sets the commit flag.
  task automatic commit;
    wr(`OLC_ADDR_VP_CTRL, 32'h1 << `OLC_COMMIT_BIT);
  endtask

  // Restarts the panel counters.
  task automatic clr_cnt;
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask

  // Prints the end of one test.
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Address of entry i of a register bank.
  function automatic [7:0] off(input logic [7:0] b, input logic [1:0] i);
    return b + {4'h0, i, 2'b00};
  endfunction

  // Placement word with the position fields in place.
  function automatic [31:0] place(input logic [11:0] x, input logic [11:0] y);
    return {1'b0, y, 1'b0, x, 6'h00};
  endfunction

  // Pixel value shown for layer i.
  function automatic [23:0] pixv(input logic [1:0] i);
    return {8'h00, {6'h00, i} + 8'h01, 8'hff};
  endfunction

  // Count of active slots at or beyond a position.
  function automatic [15:0] area(input logic [11:0] x, input logic [11:0] y);
    return 16'((`OLC_H_ACTIVE - x) * (`OLC_V_ACTIVE - y));
  endfunction

  // --------------------------
  // Tests
  // --------------------------
  // Watchdog that ends a hung run.
  initial begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    end_sim;
  end

  // Main sequence.
  initial begin
    k = 2'($unsigned($random(seed)) % 3 + 1);
    px = 12'($unsigned($random(seed)) % 16);
    py = 12'($unsigned($random(seed)) % 7 + 1);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rdw(`OLC_ADDR_STATUS);
    `CHK("state", 3'b001, rd[2:0])
    `CHK("irq", 1'b0, irq)
    rdw(8'h80);
    `CHK("unmapped read", `OLC_RESP_SLVERR, resp)
    wr(8'h84, 32'h1);
    `CHK("unmapped write", `OLC_RESP_SLVERR, resp)
    wr(`OLC_ADDR_IRQ_EN, 32'h1);
    done("reset");
    wait_frame;
    wr(`OLC_ADDR_PLACE0, place(12'h000, 12'h001));
    wr(off(`OLC_ADDR_PLACE0, k), place(px, py));
    wr(`OLC_ADDR_LAYER0, 32'h1);
    wr(off(`OLC_ADDR_LAYER0, k), 32'h1);
    commit;
    rdw(`OLC_ADDR_VP_CTRL);
    `CHK("commit pending", 1'b1, rd[`OLC_COMMIT_BIT])
    wait_frame;
    rdw(`OLC_ADDR_VP_CTRL);
    `CHK("commit cleared", 1'b0, rd[`OLC_COMMIT_BIT])
    match <= pixv(k);
    clr_cnt;
    wait_frame;
    `CHK("layer hits", area(px, py), hits)
    done("enable");
    wr(off(`OLC_ADDR_LAYER0, k), 32'h0);
    commit;
    wait_frame;
    match <= pixv(2'd0);
    clr_cnt;
    wait_frame;
    `CHK("base hits", area(12'h000, 12'h001), hits)
    `CHK("lost cycles", 16'h0000, lost)
    `CHK("line syncs", 16'(`OLC_V_TOTAL), hrise)
    `CHK("frame syncs", 16'h0001, vrise)
    done("same frame");
    wr(off(`OLC_ADDR_LAYER0, k), 32'h1);
    commit;
    wait_frame;
    clr_cnt;
    wr(off(`OLC_ADDR_LAYER0, k), 32'h0);
    wait_frame;
    rdw(`OLC_ADDR_STATUS);
    `CHK("armed", 3'b010, rd[2:0])
    commit;
    wait_frame;
    `CHK("sync lost", 1'b1, sync_lost)
    wait_frame;
    `CHK("lost cycles", 16'(`OLC_H_TOTAL * `OLC_V_TOTAL), lost)
    `CHK("blank slots", 16'h0000, bad)
    clr_cnt;
    wait_frame;
    `CHK("base hits", area(12'h000, 12'h001), hits)
    `CHK("lost cycles", 16'h0000, lost)
    rdw(`OLC_ADDR_IRQ_STAT);
    `CHK("events", 2'b11, rd[2:1])
    done("split frame");
    wr(off(`OLC_ADDR_LAYER0, k), 32'h1);
    commit;
    wait_frame;
    wr(off(`OLC_ADDR_PLACE0, k), place(`OLC_POS_MAX, `OLC_POS_MAX));
    tracker[k] = 1'b1;
    commit;
    repeat (10) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      if (tracker[i]) begin
        wr(off(`OLC_ADDR_LAYER0, 2'(i)), 32'h0);
        tracker[i] = 1'b0;
      end
    end
    commit;
    wait_frame;
    clr_cnt;
    wait_frame;
    `CHK("lost cycles", 16'h0000, lost)
    `CHK("base hits", area(12'h000, 12'h001), hits)
    done("parked disable");
    wr(`OLC_ADDR_IRQ_EN, 32'h0);
    wr(`OLC_ADDR_IRQ_CLR, 32'h7);
    repeat (400) @(posedge aclk);
    `CHK("masked irq", 1'b0, irq)
    rdw(`OLC_ADDR_IRQ_STAT);
    `CHK("frame event", 1'b1, rd[`OLC_IRQ_FRAME])
    rdw(`OLC_ADDR_IRQ_CLR);
    `CHK("clear reads", 32'h0, rd)
    wr(`OLC_ADDR_IRQ_EN, 32'h1);
    `CHK("enabled irq", 1'b1, irq)
    wr(`OLC_ADDR_IRQ_CLR, 32'h1);
    `CHK("cleared irq", 1'b0, irq)
    done("interrupt");
    end_sim;
  end
endmodule
